// *** verification/fes_exception_sync_properties.sv ***
// Checker for the exception synchronisation unit.
// Assumes it is bound to the unit's top module.
`timescale 1ns/1ns
`include "fes_defs.vh"
module fes_exception_sync_properties (
	input wire hclk,
	input wire hresetn,
	input wire issue_valid,
	input wire [`FES_KIND_W-1:0] issue_kind,
	input wire ignore_numeric_error_in,
	input wire intr_ack,
	input wire issue_accept,
	input wire core_frozen,
	input wire handler_req,
	input wire float_error_out,
	input wire stack_fault_flag
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire run = !core_frozen && !handler_req;
	wire offer = issue_valid && run && !issue_accept;
	wire ign = ignore_numeric_error_in;
	wire waits = issue_kind == `FES_KIND_WAIT ||
		issue_kind == `FES_KIND_FP_WAIT;
	property p_int_go;
		offer && issue_kind == `FES_KIND_INT |=> issue_accept;
	endproperty
	a_int_go: assert property (p_int_go) else $error("int refused");
	property p_nowait_go;
		offer && issue_kind == `FES_KIND_FP_NOWAIT |=> issue_accept;
	endproperty
	a_nowait_go: assert property (p_nowait_go) else $error("nowait");
	property p_ign_go;
		offer && ign && waits |=> issue_accept;
	endproperty
	a_ign_go: assert property (p_ign_go) else $error("ignore");
	property p_freeze;
		offer && !ign && float_error_out && waits |=> core_frozen;
	endproperty
	a_freeze: assert property (p_freeze) else $error("no freeze");
	property p_stopped;
		!run |=> !issue_accept;
	endproperty
	a_stopped: assert property (p_stopped) else $error("accepted");
	property p_enter;
		core_frozen && intr_ack && !ign |=> handler_req && !core_frozen;
	endproperty
	a_enter: assert property (p_enter) else $error("no handler");
	property p_cause;
		$rose(core_frozen) |-> $past(issue_valid) && !$past(ign);
	endproperty
	a_cause: assert property (p_cause) else $error("bad freeze");
	property p_thaw;
		core_frozen && ign |-> ##[1:3] !core_frozen;
	endproperty
	a_thaw: assert property (p_thaw) else $error("stays frozen");
	property p_sf_keep;
		stack_fault_flag && !issue_valid && !$past(issue_valid) &&
			!$past(issue_valid, 2) |=> stack_fault_flag;
	endproperty
	a_sf_keep: assert property (p_sf_keep) else $error("sf lost");
endmodule // fes_exception_sync_properties
bind fes_exception_sync fes_exception_sync_properties u_props (
	.hclk(hclk), .hresetn(hresetn), .issue_valid(issue_valid),
	.issue_kind(issue_kind), .intr_ack(intr_ack),
	.ignore_numeric_error_in(ignore_numeric_error_in),
	.issue_accept(issue_accept), .core_frozen(core_frozen),
	.handler_req(handler_req), .float_error_out(float_error_out),
	.stack_fault_flag(stack_fault_flag));

// *** verification/fes_exception_sync_tb.sv ***
// Self-checking bench for the exception synchronisation unit.
// Assumes the unit, its checker and the interrupt model are compiled.
`timescale 1ns/1ns
`include "fes_defs.vh"
module fes_exception_sync_tb;
	reg hclk, hresetn, hsel, hwrite, issue_valid, issue_push, issue_pop;
	reg ignore_numeric_error_in, ic_enable, acc;
	reg [31:0] haddr, hwdata, issue_addr, rd;
	reg [1:0] htrans;
	reg [2:0] hsize, issue_kind;
	reg [15:0] issue_opcode;
	reg [5:0] issue_load_flags, exc_raise, r;
	reg [3:0] ack_delay;
	wire [31:0] hrdata;
	wire hreadyout, hresp, intr_ack, issue_accept, core_frozen;
	wire handler_req, float_error_out, stack_fault_flag, irq;
	integer bad_count, samples_checked, cycles, i;
	fes_exception_sync dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .issue_valid(issue_valid),
		.issue_kind(issue_kind), .issue_opcode(issue_opcode),
		.issue_addr(issue_addr), .issue_push(issue_push),
		.issue_pop(issue_pop), .issue_load_flags(issue_load_flags),
		.exc_raise(exc_raise), .intr_ack(intr_ack), .irq(irq),
		.ignore_numeric_error_in(ignore_numeric_error_in),
		.issue_accept(issue_accept), .core_frozen(core_frozen),
		.handler_req(handler_req), .float_error_out(float_error_out),
		.stack_fault_flag(stack_fault_flag));
	fes_irq_ctl_model ic (.hclk(hclk), .hresetn(hresetn),
		.float_error_out(float_error_out), .enable(ic_enable),
		.ack_delay(ack_delay), .intr_ack(intr_ack));
	function [31:0] exp_status(input sf, input [5:0] f);
		exp_status = {25'h0, sf, f};
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("wrong value at %0t: %h %h", $time, got, exp);
			end
		end
	endtask
	task flag(input b, input e);
		chk({31'h0, b}, {31'h0, e});
	endtask
	task bus(input wr, input [31:0] a, input [31:0] d);
		begin
			@(posedge hclk);
			{hsel, htrans, haddr, hwrite} <= {3'b110, a, wr};
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			{hsel, htrans, hwdata} <= {3'b000, d};
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			rd = hrdata;
			chk({31'h0, hresp}, 32'h0000_0000);
		end
	endtask
	task issue(input [2:0] k, input pu, input po);
		integer n;
		begin
			@(posedge hclk);
			{issue_valid, issue_kind, issue_push, issue_pop} <= {1'b1, k, pu, po};
			issue_opcode <= 16'($urandom);
			issue_addr <= $urandom;
			acc = 1'b0;
			for (n = 0; n < 4 && !acc; n = n + 1) begin
				@(posedge hclk);
				acc = issue_accept === 1'b1;
			end
			{issue_valid, issue_push, issue_pop} <= 3'b000;
		end
	endtask
	task raise(input [5:0] f);
		begin
			@(posedge hclk);
			exc_raise <= f;
			@(posedge hclk);
			exc_raise <= 6'h00;
			repeat (2) @(posedge hclk);
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			summarize;
		end
	end
	initial begin
		{hresetn, hsel, hwrite, issue_valid, issue_push, issue_pop} = 6'h00;
		{ignore_numeric_error_in, ic_enable, htrans, issue_kind} = 7'h00;
		{haddr, hwdata, issue_addr, issue_opcode} = 112'h0;
		{issue_load_flags, exc_raise, ack_delay} = 16'h0000;
		hsize = 3'h2;
		{bad_count, samples_checked, cycles} = 96'h0;
		i = $urandom(17);
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `FES_OFF_MASK, 0);
		chk(rd, 32'h0000_003F);
		bus(1, 32'h0000_0040, 32'hFFFF_FFFF);
		bus(0, 32'h0000_0040, 0);
		chk(rd, 32'h0000_0000);
		bus(1, `FES_OFF_CTRL, 32'h0000_0001);
		bus(0, `FES_OFF_CTRL, 0);
		chk(rd, 32'h0000_0001);
		bus(1, `FES_OFF_CTRL, 0);
		$display("registers done");
		for (i = 4; i < 8; i = i + 1) begin
			r = 6'($urandom) | 6'h01;
			issue_load_flags <= 6'($urandom);
			raise(r);
			issue(`FES_KIND_INT, 0, 0);
			flag(acc, 1'b1);
			issue(`FES_KIND_FP_WAIT, 0, 0);
			flag(acc, 1'b1);
			flag(float_error_out, 1'b0);
			bus(0, `FES_OFF_STATUS, 0);
			chk(rd, exp_status(1'b0, r));
			issue(i[2:0], 0, 0);
			bus(0, `FES_OFF_STATUS, 0);
			chk(rd, exp_status(1'b0, i == 7 ? issue_load_flags : 6'h00));
			bus(0, `FES_OFF_CTX_OP, 0);
			chk(rd, {16'h0000, issue_opcode});
			bus(0, `FES_OFF_CTX_ADDR, 0);
			chk(rd, issue_addr);
		end
		$display("masked done");
		bus(1, `FES_OFF_MASK, 32'h0000_003E);
		raise(6'h01);
		flag(float_error_out, 1'b1);
		issue(`FES_KIND_INT, 0, 0);
		flag(acc, 1'b1);
		issue(`FES_KIND_FP_NOWAIT, 0, 0);
		flag(acc, 1'b1);
		issue(`FES_KIND_FP_WAIT, 0, 0);
		flag(acc, 1'b0);
		flag(core_frozen, 1'b1);
		ack_delay <= 4'($urandom % 8);
		ic_enable <= 1'b1;
		for (i = 0; i < 40 && handler_req !== 1'b1; i = i + 1) @(posedge hclk);
		ic_enable <= 1'b0;
		flag(handler_req, 1'b1);
		bus(1, `FES_OFF_MASK, 32'h0000_003F);
		repeat (3) @(posedge hclk);
		flag(handler_req, 1'b0);
		issue(`FES_KIND_FP_WAIT, 0, 0);
		flag(acc, 1'b1);
		bus(1, `FES_OFF_MASK, 32'h0000_003E);
		ignore_numeric_error_in <= 1'b1;
		issue(`FES_KIND_WAIT, 0, 0);
		flag(acc, 1'b1);
		ignore_numeric_error_in <= 1'b0;
		issue(`FES_KIND_WAIT, 0, 0);
		flag(core_frozen, 1'b1);
		ignore_numeric_error_in <= 1'b1;
		repeat (4) @(posedge hclk);
		flag(core_frozen, 1'b0);
		ignore_numeric_error_in <= 1'b0;
		bus(1, `FES_OFF_MASK, 32'h0000_003F);
		$display("unmasked done");
		issue(`FES_KIND_REINIT, 0, 0);
		issue(`FES_KIND_FP_NOWAIT, 0, 1);
		repeat (2) @(posedge hclk);
		flag(stack_fault_flag, 1'b1);
		issue(`FES_KIND_REINIT, 0, 0);
		bus(0, `FES_OFF_IRQ_STAT, 0);
		for (i = 0; i < 9; i = i + 1)
			issue(`FES_KIND_FP_NOWAIT, 1, 0);
		repeat (2) @(posedge hclk);
		bus(0, `FES_OFF_STATUS, 0);
		chk(rd, exp_status(1'b1, 6'h01));
		flag(irq, 1'b0);
		bus(1, `FES_OFF_IRQ_MASK, 32'h0000_000F);
		repeat (2) @(posedge hclk);
		flag(irq, 1'b1);
		bus(0, `FES_OFF_IRQ_STAT, 0);
		chk(rd, 32'h0000_0009);
		repeat (2) @(posedge hclk);
		flag(irq, 1'b0);
		$display("stack done");
		summarize;
	end
endmodule // fes_exception_sync_tb

// *** verification/fes_irq_ctl_model.sv ***
// Interrupt controller model answering the unit's error output.
// Assumes the core takes the interrupt as one acknowledge pulse.
`timescale 1ns/1ns
module fes_irq_ctl_model (
	input wire hclk,
	input wire hresetn,
	input wire float_error_out,
	input wire enable,
	input wire [3:0] ack_delay,
	output reg intr_ack
);
	reg [3:0] count;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			intr_ack <= 1'b0;
			count <= 4'h0;
		end else begin
			intr_ack <= 1'b0;
			count <= 4'h0;
			// Request presented again while the error stands
			if (float_error_out && enable) begin
				if (count == ack_delay)
					intr_ack <= 1'b1;
				else
					count <= count + 4'h1;
			end
		end
	end
endmodule // fes_irq_ctl_model

// *** verilog/fes_defs.vh ***
// Constants for the floating-point exception synchronisation unit.
// Assumes a single 100 MHz core clock and a 32-bit AHB-Lite bus.
`ifndef FES_DEFS_VH
`define FES_DEFS_VH

// Register byte offsets
`define FES_OFF_CTRL 12'h000
`define FES_OFF_STATUS 12'h004
`define FES_OFF_MASK 12'h008
`define FES_OFF_CTX_OP 12'h00C
`define FES_OFF_CTX_ADDR 12'h010
`define FES_OFF_IRQ_STAT 12'h014
`define FES_OFF_IRQ_MASK 12'h018
`define FES_OFF_STATE 12'h01C

// Exception flag positions, shared by status and mask words; the stack fault bit is in status only
`define FES_EXC_W 6
`define FES_EXC_INVALID 0
`define FES_EXC_DENORM 1
`define FES_EXC_ZDIV 2
`define FES_EXC_OVER 3
`define FES_EXC_UNDER 4
`define FES_EXC_PREC 5
`define FES_BIT_STACK_FAULT 6

// Control word fields
`define FES_CTRL_NE 0

// Interrupt status bits
`define FES_IRQ_W 4
`define FES_IRQ_MASKED 0
`define FES_IRQ_UNMASKED 1
`define FES_IRQ_FREEZE 2
`define FES_IRQ_STACK 3

// Reset values
`define FES_RST_MASK 6'h3F
`define FES_RST_CTRL 1'b0

// Instruction kinds presented on the issue port
`define FES_KIND_W 3
`define FES_KIND_INT 3'h0
`define FES_KIND_WAIT 3'h1
`define FES_KIND_FP_WAIT 3'h2
`define FES_KIND_FP_NOWAIT 3'h3
`define FES_KIND_CLEAR 3'h4
`define FES_KIND_REINIT 3'h5
`define FES_KIND_SAVE 3'h6
`define FES_KIND_LOAD_ENV 3'h7

// Register stack depth
`define FES_STACK_DEPTH 4'h8

`endif

// *** verilog/fes_exception_sync.v ***
// Floating-point exception synchronisation unit with AHB-Lite registers.
// Assumes the issue stage holds an instruction until accepted.
// Behaviour
// - Each accepted numeric instruction records its opcode and address.
// - A masked exception only sets its flag; execution continues.
// - An unmasked exception stops and requests the software handler.
// - Push to full or pop from empty sets stack fault and invalid.
// - With an unmasked exception pending, wait or waiting FP freezes.
// - No freeze when ignore-numeric-error is high or form is no-wait.
// - The error output rises one cycle after the pending condition.
// - Integer instructions proceed regardless of pending exceptions; the code holds them while frozen or in handler.
// - Earlier errors are reported at the next wait or waiting FP instruction.
// - A wait forces a pending exception to be serviced first.
// - Flags stay set until clear, reinit, save or a state load.
// - With native reporting off and ignore input high, go on.
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "fes_defs.vh"

module fes_exception_sync (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire issue_valid,
	input wire [`FES_KIND_W-1:0] issue_kind,
	input wire [15:0] issue_opcode,
	input wire [31:0] issue_addr,
	input wire issue_push,
	input wire issue_pop,
	input wire [`FES_EXC_W-1:0] issue_load_flags,
	input wire [`FES_EXC_W-1:0] exc_raise,
	input wire ignore_numeric_error_in,
	input wire intr_ack,
	output reg issue_accept,
	output reg core_frozen,
	output reg handler_req,
	output reg float_error_out,
	output reg stack_fault_flag,
	output reg irq
);
	localparam ST_RUN = 2'h0;
	localparam ST_FROZEN = 2'h1;
	localparam ST_HANDLER = 2'h2;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [`FES_EXC_W-1:0] exc_flags;
	reg [`FES_EXC_W-1:0] next_exc_flags;
	reg [`FES_EXC_W-1:0] exc_mask;
	reg native_error_report_enable;
	reg [15:0] ctx_opcode;
	reg [31:0] ctx_addr;
	reg [`FES_IRQ_W-1:0] irq_stat;
	reg [`FES_IRQ_W-1:0] irq_mask;
	reg [`FES_IRQ_W-1:0] irq_event;
	reg next_stack_fault;
	reg ph_valid;
	reg ph_write;
	reg [11:0] ph_addr;
	reg [31:0] rd_word;

	wire pending;
	wire is_fp;
	wire needs_sync;
	wire freeze_now;
	wire clear_op;
	wire clear_exceptions_op;
	wire reinit_unit_op;
	wire save_op;
	wire load_op;
	wire take;
	wire stk_fault;
	wire [3:0] stk_depth;
	wire bus_start;
	wire wr_ctrl;
	wire wr_mask;
	wire wr_irq_mask;
	wire rd_irq_stat;
	wire [`FES_EXC_W-1:0] masked_raise;
	wire [`FES_EXC_W-1:0] raise_all;
	wire [`FES_IRQ_W-1:0] next_irq_stat;

	genvar gi;

	assign pending = |(exc_flags & ~exc_mask);
	assign is_fp = (issue_kind != `FES_KIND_INT) &&
		(issue_kind != `FES_KIND_WAIT);
	// Waiting forms synchronise; control forms are no-wait
	assign needs_sync = (issue_kind == `FES_KIND_WAIT) ||
		(issue_kind == `FES_KIND_FP_WAIT);
	// Ignore input suppresses the freeze in either reporting mode
	// A request whose accept pulse stands was already taken
	assign freeze_now = issue_valid && !issue_accept && needs_sync &&
		pending && !ignore_numeric_error_in;
	assign clear_exceptions_op = (issue_kind == `FES_KIND_CLEAR);
	assign reinit_unit_op = (issue_kind == `FES_KIND_REINIT);
	assign save_op = (issue_kind == `FES_KIND_SAVE);
	assign load_op = (issue_kind == `FES_KIND_LOAD_ENV);
	assign clear_op = clear_exceptions_op || reinit_unit_op || save_op;
	assign take = issue_valid && !issue_accept && (state == ST_RUN) &&
		!freeze_now;
	assign raise_all = exc_raise |
		({{(`FES_EXC_W-1){1'b0}}, stk_fault} << `FES_EXC_INVALID);
	assign masked_raise = raise_all & exc_mask;

	fes_stack_track u_stack (
		.hclk(hclk),
		.hresetn(hresetn),
		.push(take && issue_push),
		.pop(take && issue_pop),
		.reinit(take && reinit_unit_op),
		.fault(stk_fault),
		.depth(stk_depth)
	);

	// Exception flags: accumulate, cleared only by listed operations
	always @* begin
		next_exc_flags = exc_flags;
		next_stack_fault = stack_fault_flag;
		if (take && clear_op) begin
			next_exc_flags = {`FES_EXC_W{1'b0}};
			next_stack_fault = 1'b0;
		end else if (take && load_op) begin
			next_exc_flags = issue_load_flags;
		end
		// Raised flags win over a clear in the same cycle
		next_exc_flags = next_exc_flags | raise_all;
		if (stk_fault) begin
			next_stack_fault = 1'b1;
		end
	end

	always @* begin
		next_state = state;
		case (state)
		ST_RUN: begin
			if (freeze_now && (state == ST_RUN)) begin
				next_state = ST_FROZEN;
			end
		end
		ST_FROZEN: begin
			if (!pending || ignore_numeric_error_in) begin
				next_state = ST_RUN;
			end else if (intr_ack) begin
				next_state = ST_HANDLER;
			end
		end
		ST_HANDLER: begin
			// Handler state accepts no instructions; it leaves once no unmasked flag is pending
			if (!pending) begin
				next_state = ST_RUN;
			end
		end
		default: begin
			next_state = ST_RUN;
		end
		endcase
	end

	always @* begin
		irq_event = {`FES_IRQ_W{1'b0}};
		irq_event[`FES_IRQ_MASKED] = |masked_raise;
		irq_event[`FES_IRQ_UNMASKED] = |(raise_all & ~exc_mask);
		irq_event[`FES_IRQ_FREEZE] = (state == ST_RUN) &&
			(next_state == ST_FROZEN);
		irq_event[`FES_IRQ_STACK] = stk_fault;
	end

	// Core-side state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_RUN;
			exc_flags <= {`FES_EXC_W{1'b0}};
			stack_fault_flag <= 1'b0;
			ctx_opcode <= 16'h0000;
			ctx_addr <= 32'h0000_0000;
			issue_accept <= 1'b0;
			core_frozen <= 1'b0;
			handler_req <= 1'b0;
			float_error_out <= 1'b0;
		end else begin
			state <= next_state;
			exc_flags <= next_exc_flags;
			stack_fault_flag <= next_stack_fault;
			// Integer work never freezes, but is held while frozen or in the handler state
			issue_accept <= take;
			if (take && is_fp) begin
				ctx_opcode <= issue_opcode;
				ctx_addr <= issue_addr;
			end
			core_frozen <= (next_state == ST_FROZEN);
			handler_req <= (next_state == ST_HANDLER);
			// Error pin follows pending; NE mode gates neither the pin nor the freeze
			float_error_out <= pending;
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	assign bus_start = hsel && hready && htrans[1];
	assign wr_ctrl = ph_valid && ph_write && (ph_addr == `FES_OFF_CTRL);
	assign wr_mask = ph_valid && ph_write && (ph_addr == `FES_OFF_MASK);
	assign wr_irq_mask = ph_valid && ph_write &&
		(ph_addr == `FES_OFF_IRQ_MASK);
	assign rd_irq_stat = bus_start && !hwrite &&
		(haddr[11:0] == `FES_OFF_IRQ_STAT);

	// Sticky interrupt status per bit; a new event beats the read clear
	generate
		for (gi = 0; gi < `FES_IRQ_W; gi = gi + 1) begin : g_irq_bit
			assign next_irq_stat[gi] = irq_event[gi] ||
				(irq_stat[gi] && !rd_irq_stat);
		end
	endgenerate

	always @* begin
		rd_word = 32'h0000_0000;
		case (haddr[11:0])
		`FES_OFF_CTRL: rd_word[`FES_CTRL_NE] = native_error_report_enable;
		`FES_OFF_STATUS: begin
			rd_word[`FES_EXC_W-1:0] = exc_flags;
			rd_word[`FES_BIT_STACK_FAULT] = stack_fault_flag;
		end
		`FES_OFF_MASK: rd_word[`FES_EXC_W-1:0] = exc_mask;
		`FES_OFF_CTX_OP: rd_word[15:0] = ctx_opcode;
		`FES_OFF_CTX_ADDR: rd_word = ctx_addr;
		`FES_OFF_IRQ_STAT: rd_word[`FES_IRQ_W-1:0] = irq_stat;
		`FES_OFF_IRQ_MASK: rd_word[`FES_IRQ_W-1:0] = irq_mask;
		`FES_OFF_STATE: begin
			rd_word[1:0] = state;
			rd_word[7:4] = stk_depth;
		end
		default: rd_word = 32'h0000_0000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 12'h000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			native_error_report_enable <= `FES_RST_CTRL;
			exc_mask <= `FES_RST_MASK;
			irq_mask <= {`FES_IRQ_W{1'b0}};
			irq_stat <= {`FES_IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ph_valid <= bus_start;
			ph_write <= hwrite;
			ph_addr <= haddr[11:0];
			if (bus_start && !hwrite) begin
				hrdata <= rd_word;
			end
			if (wr_ctrl) begin
				native_error_report_enable <= hwdata[`FES_CTRL_NE];
			end
			if (wr_mask) begin
				exc_mask <= hwdata[`FES_EXC_W-1:0];
			end
			if (wr_irq_mask) begin
				irq_mask <= hwdata[`FES_IRQ_W-1:0];
			end
			irq_stat <= next_irq_stat;
			irq <= |(irq_mask & next_irq_stat);
		end
	end
endmodule // fes_exception_sync

// *** verilog/fes_stack_track.v ***
// Register-stack occupancy tracker with push/pop fault detection.
// Assumes one push or pop request per cycle from the issue stage.
`timescale 1ns/1ns
`include "fes_defs.vh"

module fes_stack_track (
	input wire hclk,
	input wire hresetn,
	input wire push,
	input wire pop,
	input wire reinit,
	output reg fault,
	output reg [3:0] depth
);
	wire full;
	wire empty;

	assign full = (depth == `FES_STACK_DEPTH);
	assign empty = (depth == 4'h0);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			depth <= 4'h0;
			fault <= 1'b0;
		end else begin
			fault <= 1'b0;
			if (reinit) begin
				depth <= 4'h0;
			end else if (push && full) begin
				fault <= 1'b1;
			end else if (pop && empty) begin
				fault <= 1'b1;
			end else if (push && !pop) begin
				depth <= depth + 4'h1;
			end else if (pop && !push) begin
				depth <= depth - 4'h1;
			end
		end
	end
endmodule // fes_stack_track
